// File: core/rcc_top.v
// reset cause controller: merges every reset source into the master system reset and keeps
// the reset cause status register. assumes source inputs are levels or pulses from pins or
// logic in other domains; each is synchronised here. the oscillator start-up count uses a
// rising edge of the period tick that the clock generator supplies once per oscillator period, synchronised here.
// Overview of operation
// - power-on, brown-out, pin, instruction, watchdog, trap, illegal-op feed one reset
// - master reset is asserted while any reset source is active
// - unrelated registers keep contents across resets other than power-on
// - power-on clears all cause flags except brown-out flag bit 1 and power-on flag bit 0
// - software may set or clear any status bit at any time
// - software writing a flag only stores it, no reset follows
// - trap and illegal-op flags set by their events, cleared by power-on or brown-out
// - pin reset flag set by pin reset, cleared only by power-on
// - software reset flag set by reset instruction, cleared by power-on or brown-out
// - watchdog flag set on time-out, cleared by power-save, power-on or brown-out
// - sleep flag set on entering sleep, cleared by power-on or brown-out
// - idle flag set on entering idle, cleared by power-on or brown-out
// - brown-out flag set by brown-out or power-on, power-on flag by power-on
// - soft watchdog enable works unless the watchdog fuse is unprogrammed
// - without clock switching, reset clock source comes from oscillator fuses
// - master reset released only after power-on and power-up delays expire
// - pin, watchdog, software, illegal-op, trap resets hold reset twenty microseconds
// - crystal source counts 1024 oscillator periods before releasing oscillator clock
`timescale 1ns/100ps
`include "rcc_map.vh"

module rcc_top (
    // clock and power-on reset
    input  wire        mclk,
    input  wire        rst_n,
    // reset sources
    input  wire        brown_out_reset,
    input  wire        external_pin_reset,
    input  wire        reset_instruction,
    input  wire        watchdog_timeout,
    input  wire        trap_conflict,
    input  wire        illegal_opcode,
    // power-save instruction events
    input  wire        power_save_sleep,
    input  wire        power_save_idle,
    // configuration fuses and oscillator
    input  wire        watchdog_config_fuse,
    input  wire        clock_switch_fuse,
    input  wire [2:0]  osc_config_fuse,
    input  wire [2:0]  osc_current_sel,
    input  wire        crystal_source,
    input  wire        osc_period_tick,
    // register port
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [15:0] reg_rdata,
    // outputs
    output reg         master_system_reset,
    output reg         watchdog_enable,
    output reg  [2:0]  reset_clock_sel,
    output reg         osc_clock_release
);

    // ==========================================
    // reset release
    reg        rst_s1_r;
    reg        rst_s2_r;
    wire       por_rst_n = rst_s2_r;

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r <= 1'b0;
            rst_s2_r <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    // ==========================================
    // input synchronisers, one generate loop over the event inputs
    localparam NSRC = 9;
    wire [NSRC-1:0] src_raw = {power_save_idle, power_save_sleep, illegal_opcode, trap_conflict,
                               watchdog_timeout, reset_instruction, external_pin_reset,
                               brown_out_reset, osc_period_tick};
    wire [NSRC-1:0] src_s;
    genvar gi;
    generate
        for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_sync
            reg s1_r;
            reg s2_r;
            always @(posedge mclk or negedge por_rst_n) begin
                if (!por_rst_n) begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                end else begin
                    s1_r <= src_raw[gi];
                    s2_r <= s1_r;
                end
            end
            assign src_s[gi] = s2_r;
        end
    endgenerate

    reg        fuse_s1_r;
    reg        fuse_s2_r;
    reg        csw_s1_r;
    reg        csw_s2_r;
    always @(posedge mclk or negedge por_rst_n) begin
        if (!por_rst_n) begin
            fuse_s1_r <= 1'b1;
            fuse_s2_r <= 1'b1;
            csw_s1_r  <= 1'b0;
            csw_s2_r  <= 1'b0;
        end else begin
            fuse_s1_r <= watchdog_config_fuse;
            fuse_s2_r <= fuse_s1_r;
            csw_s1_r  <= clock_switch_fuse;
            csw_s2_r  <= csw_s1_r;
        end
    end

    wire tick_s  = src_s[0];
    wire bor_s   = src_s[1];
    wire pin_s   = src_s[2];
    wire swr_s   = src_s[3];
    wire wdt_s   = src_s[4];
    wire trap_s  = src_s[5];
    wire illop_s = src_s[6];
    wire sleep_s = src_s[7];
    wire idle_s  = src_s[8];

    // previous levels for edge detection of pulse events
    reg  [NSRC-1:0] src_d_r;
    always @(posedge mclk or negedge por_rst_n) begin
        if (!por_rst_n) begin
            src_d_r <= {NSRC{1'b0}};
        end else begin
            src_d_r <= src_s;
        end
    end
    wire [NSRC-1:0] src_rise = src_s & ~src_d_r;

    // ==========================================
    // reset sequencing
    localparam ST_POR   = 2'd0;
    localparam ST_START = 2'd1;
    localparam ST_HOLD  = 2'd2;
    localparam ST_RUN   = 2'd3;

    // counts are worked out as 32-bit integers, then cut to the counter width on purpose
    localparam integer TPOR_I  = `RCC_TPOR_CYC;
    localparam integer TSTRT_I = `RCC_TSTARTUP_CYC;
    localparam integer TRST_I  = `RCC_TRST_CYC;
    localparam [15:0]  TPOR_C  = TPOR_I[15:0];
    localparam [15:0]  TSTRT_C = TSTRT_I[15:0];
    localparam [15:0]  TRST_C  = TRST_I[15:0];

    reg  [1:0]  state_r;
    reg  [1:0]  state_nxt;
    reg  [15:0] cnt_r;
    reg  [15:0] cnt_nxt;
    reg         bor_seen_r;
    reg         bor_seen_nxt;
    wire        warm_src = pin_s | swr_s | wdt_s | trap_s | illop_s;
    wire        any_src  = warm_src | bor_s;

    always @* begin
        state_nxt    = state_r;
        cnt_nxt      = cnt_r;
        // sticky until power-on so software can still see it long after the event
        bor_seen_nxt = bor_seen_r;
        case (state_r)
            ST_POR: begin
                if (cnt_r == TPOR_C - 16'h0001) begin
                    state_nxt = ST_START;
                    cnt_nxt   = 16'h0000;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            ST_START: begin
                if (bor_s) begin
                    cnt_nxt = 16'h0000;
                end else if (cnt_r == TSTRT_C - 16'h0001) begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = 16'h0000;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            ST_HOLD: begin
                if (bor_s) begin
                    state_nxt = ST_START;
                    cnt_nxt   = 16'h0000;
                end else if (warm_src) begin
                    cnt_nxt = 16'h0000;
                end else if (cnt_r == TRST_C - 16'h0001) begin
                    state_nxt = ST_RUN;
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            default: begin
                if (bor_s) begin
                    state_nxt    = ST_START;
                    cnt_nxt      = 16'h0000;
                    bor_seen_nxt = 1'b1;
                end else if (warm_src) begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = 16'h0000;
                end
            end
        endcase
    end

    always @(posedge mclk or negedge por_rst_n) begin
        if (!por_rst_n) begin
            state_r    <= ST_POR;
            cnt_r      <= 16'h0000;
            bor_seen_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= cnt_nxt;
            bor_seen_r <= bor_seen_nxt;
        end
    end

    // brown-out seen in any state clears the brown-out-cleared flags
    wire bor_clr = src_rise[1];

    // ==========================================
    // reset cause status register
    reg  [15:0] cause_r;
    reg  [15:0] cause_nxt;
    reg         clksw_r;
    reg  [2:0]  osc_sel_r;
    wire        wr_cause = reg_wr && (reg_addr == `RCC_CAUSE_ADDR);
    wire        wr_ctrl  = reg_wr && (reg_addr == `RCC_CTRL_ADDR);

    always @* begin
        cause_nxt = cause_r;
        if (wr_cause) begin
            cause_nxt = reg_wdata & `RCC_CAUSE_MASK;
        end
        if (bor_clr) begin
            cause_nxt[`RCC_TRAP_BIT]  = 1'b0;
            cause_nxt[`RCC_ILLOP_BIT] = 1'b0;
            cause_nxt[`RCC_SWR_BIT]   = 1'b0;
            cause_nxt[`RCC_WATCHDOG_TIMEOUT_FLAG_BIT]  = 1'b0;
            cause_nxt[`RCC_SLEEP_BIT] = 1'b0;
            cause_nxt[`RCC_IDLE_BIT]  = 1'b0;
        end
        if (src_rise[7] || src_rise[8]) begin
            cause_nxt[`RCC_WATCHDOG_TIMEOUT_FLAG_BIT] = 1'b0;
        end
        // event sets are applied last so a set wins over a same-cycle clear
        if (src_rise[1])
            cause_nxt[`RCC_BOR_BIT]   = 1'b1;
        if (src_rise[2])
            cause_nxt[`RCC_EXTERNAL_PIN_RESET_FLAG_BIT]  = 1'b1;
        if (src_rise[3])
            cause_nxt[`RCC_SWR_BIT]   = 1'b1;
        if (src_rise[4])
            cause_nxt[`RCC_WATCHDOG_TIMEOUT_FLAG_BIT]  = 1'b1;
        if (src_rise[5])
            cause_nxt[`RCC_TRAP_BIT]  = 1'b1;
        if (src_rise[6])
            cause_nxt[`RCC_ILLOP_BIT] = 1'b1;
        if (src_rise[7])
            cause_nxt[`RCC_SLEEP_BIT] = 1'b1;
        if (src_rise[8])
            cause_nxt[`RCC_IDLE_BIT]  = 1'b1;
    end

    // power-on leaves only brown-out and power-on flags set; every other flag
    // collects all sources that fire together
    always @(posedge mclk or negedge por_rst_n) begin
        if (!por_rst_n) begin
            cause_r   <= `RCC_CAUSE_POR_VAL;
            clksw_r   <= 1'b0;
            osc_sel_r <= 3'h0;
        end else begin
            cause_r <= cause_nxt;
            if (wr_ctrl) begin
                clksw_r   <= reg_wdata[`RCC_CTRL_CLKSW_BIT];
                osc_sel_r <= reg_wdata[`RCC_CTRL_OSC_MSB:`RCC_CTRL_OSC_LSB];
            end
        end
    end

    // ==========================================
    // oscillator start-up counter, counts periods of the crystal
    reg  [`RCC_OST_W-1:0] ost_cnt_r;
    reg                   ost_done_r;
    always @(posedge mclk or negedge por_rst_n) begin
        if (!por_rst_n) begin
            ost_cnt_r  <= {`RCC_OST_W{1'b0}};
            ost_done_r <= 1'b0;
        end else if (bor_s) begin
            ost_cnt_r  <= {`RCC_OST_W{1'b0}};
            ost_done_r <= 1'b0;
        end else if (!ost_done_r && src_rise[0]) begin
            ost_cnt_r <= ost_cnt_r + {{(`RCC_OST_W-1){1'b0}}, 1'b1};
            if (ost_cnt_r == {`RCC_OST_W{1'b1}})
                ost_done_r <= 1'b1;
        end
    end

    // ==========================================
    // outputs and read port
    // clock selection is latched while reset is active so a running program
    // never sees the source change under it
    always @(posedge mclk or negedge por_rst_n) begin
        if (!por_rst_n) begin
            master_system_reset <= 1'b1;
            watchdog_enable     <= 1'b1;
            reset_clock_sel     <= 3'h0;
            osc_clock_release   <= 1'b0;
            reg_rdata           <= 16'h0000;
        end else begin
            master_system_reset <= (state_nxt != ST_RUN) | any_src;
            watchdog_enable     <= fuse_s2_r | cause_r[`RCC_SWDT_BIT];
            if (state_r != ST_RUN) begin
                if (csw_s2_r && clksw_r)
                    reset_clock_sel <= osc_sel_r;
                else
                    reset_clock_sel <= osc_config_fuse;
            end
            osc_clock_release   <= ~crystal_source | ost_done_r;
            if (reg_rd && reg_addr == `RCC_CAUSE_ADDR)
                reg_rdata <= cause_r;
            else if (reg_rd && reg_addr == `RCC_CTRL_ADDR)
                reg_rdata <= {9'h000, osc_sel_r, 3'h0, clksw_r};
            else if (reg_rd && reg_addr == `RCC_TIMING_ADDR)
                reg_rdata <= {12'h000, ost_done_r, bor_seen_r, state_r};
            else
                reg_rdata <= 16'h0000;
        end
    end

endmodule

// File: core/rcc_map.vh
// register offsets, field positions, reset values and timing counts of the reset cause controller
// assumes a 100 MHz system clock and a word-wide plain register port
`ifndef RCC_MAP_VH
`define RCC_MAP_VH
// ==========================================
// register map
`define RCC_ADDR_W          4
`define RCC_CAUSE_ADDR      4'h0
`define RCC_CTRL_ADDR       4'h1
`define RCC_TIMING_ADDR     4'h2
// ==========================================
// reset_cause_status fields
`define RCC_TRAP_BIT        15
`define RCC_ILLOP_BIT       14
`define RCC_VREG_BIT        8
`define RCC_EXTERNAL_PIN_RESET_FLAG_BIT        7
`define RCC_SWR_BIT         6
`define RCC_SWDT_BIT        5
`define RCC_WATCHDOG_TIMEOUT_FLAG_BIT        4
`define RCC_SLEEP_BIT       3
`define RCC_IDLE_BIT        2
`define RCC_BOR_BIT         1
`define RCC_POR_BIT         0
`define RCC_CAUSE_MASK      16'hc1ff
`define RCC_CAUSE_POR_VAL   16'h0003
// ==========================================
// control register fields
`define RCC_CTRL_CLKSW_BIT  0
`define RCC_CTRL_OSC_LSB    4
`define RCC_CTRL_OSC_MSB    6
// ==========================================
// timing, 100 MHz clock, 10 ns period
`define RCC_CLK_NS          10
`define RCC_TPOR_NS         10000
`define RCC_TRST_NS         20000
`define RCC_TSTARTUP_NS     20000
`define RCC_TPOR_CYC        ((`RCC_TPOR_NS + `RCC_CLK_NS - 1) / `RCC_CLK_NS)
`define RCC_TRST_CYC        ((`RCC_TRST_NS + `RCC_CLK_NS - 1) / `RCC_CLK_NS)
`define RCC_TSTARTUP_CYC    ((`RCC_TSTARTUP_NS + `RCC_CLK_NS - 1) / `RCC_CLK_NS)
`define RCC_CNT_W           16
`define RCC_OST_PERIODS     1024
`define RCC_OST_W           10
`endif

// File: bench/rcc_properties.sv
// checker for the reset cause controller, watching only the top ports
// assumes it is bound onto rcc_top and that the bench holds sources high for three cycles
`timescale 1ns/100ps
`include "rcc_map.vh"
module rcc_properties (
    // clock and power-on reset
    input wire        mclk,
    input wire        rst_n,
    // sources and fuses
    input wire        brown_out_reset,
    input wire        external_pin_reset,
    input wire        reset_instruction,
    input wire        watchdog_timeout,
    input wire        trap_conflict,
    input wire        illegal_opcode,
    input wire        watchdog_config_fuse,
    input wire        clock_switch_fuse,
    input wire [2:0]  osc_config_fuse,
    input wire        crystal_source,
    input wire        osc_period_tick,
    // register port
    input wire [3:0]  reg_addr,
    input wire [15:0] reg_wdata,
    input wire        reg_wr,
    input wire        reg_rd,
    input wire [15:0] reg_rdata,
    // outputs
    input wire        master_system_reset,
    input wire        watchdog_enable,
    input wire [2:0]  reset_clock_sel,
    input wire        osc_clock_release
);
    // ==========================================
    // helper counters
    wire rst_any = brown_out_reset | external_pin_reset | reset_instruction
                 | watchdog_timeout | trap_conflict | illegal_opcode;
    reg  [15:0] quiet_r;
    reg  [15:0] up_r;
    reg  [11:0] tick_r;
    reg         tick_d_r;
    // saturating so a long run never wraps into a false failure
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            quiet_r  <= 16'h0000;
            up_r     <= 16'h0000;
            tick_r   <= 12'h000;
            tick_d_r <= 1'b0;
        end else begin
            quiet_r  <= rst_any ? 16'h0000 : quiet_r + {15'h0000, quiet_r != 16'hffff};
            up_r     <= up_r + {15'h0000, up_r != 16'hffff};
            tick_d_r <= osc_period_tick;
            tick_r   <= tick_r + {11'h000, osc_period_tick & !tick_d_r & (tick_r != 12'hfff)};
        end
    end
    // ==========================================
    // properties
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence wr_then_rd;
        reg_wr && reg_addr == `RCC_CAUSE_ADDR && quiet_r > 16'd8
        ##1 reg_rd && reg_addr == `RCC_CAUSE_ADDR;
    endsequence
    a_src_asserts_reset: assert property (
        $rose(rst_any) |-> ##[1:6] master_system_reset)
        else $error("source did not raise the master reset");
    a_reset_while_src: assert property (
        master_system_reset && rst_any |=> master_system_reset)
        else $error("master reset dropped while a source was active");
    a_reset_spans_trst: assert property (
        quiet_r > 16'd8 && quiet_r < 16'd1990 |-> master_system_reset)
        else $error("master reset released before the internal reset time");
    a_por_delay_held: assert property (up_r < 16'd4900 |-> master_system_reset)
        else $error("master reset released before the power-on delays");
    a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    a_write_readback: assert property (
        wr_then_rd |=> reg_rdata == ($past(reg_wdata, 2) & `RCC_CAUSE_MASK))
        else $error("cause register did not keep the written value");
    a_write_no_reset: assert property (
        reg_wr && reg_addr == `RCC_CAUSE_ADDR && !master_system_reset
        && quiet_r > 16'd8 |=> !master_system_reset [*6])
        else $error("writing the cause register started a reset");
    a_wdt_fuse_on: assert property (watchdog_config_fuse [*5] |-> watchdog_enable)
        else $error("watchdog not enabled with the fuse unprogrammed");
    a_clk_sel_fuse: assert property (
        !clock_switch_fuse && !master_system_reset |-> reset_clock_sel == osc_config_fuse)
        else $error("reset clock source differs from the oscillator fuses");
    a_osc_startup_hold: assert property (
        crystal_source && tick_r < 12'd1000 |-> !osc_clock_release)
        else $error("oscillator clock released before the start-up count");
    c_reset_done: cover property ($fell(master_system_reset));
    c_read_data: cover property (reg_rd ##1 reg_rdata != 16'h0000);
    c_src_in_reset: cover property (rst_any && master_system_reset);
endmodule

// File: bench/rcc_src_model.sv
// model of the on-chip reset sources and the oscillator feeding the controller
// assumes the bench pulses fire for one cycle; lines idle low as plain logic outputs
`timescale 1ns/100ps
module rcc_src_model (
    // clock
    input  wire       mclk,
    // command: bit order pin, instr, wdt, trap, illop, sleep, idle, brown-out
    input  wire       fire,
    input  wire [7:0] fire_mask,
    // lines into the controller
    output reg  [7:0] src_lines,
    output reg        osc_period_tick
);
    reg [1:0] hold_r = 2'h0;
    reg [1:0] div_r  = 2'h0;
    initial src_lines = 8'h00;
    initial osc_period_tick = 1'b0;
    // three cycles high so the two-flop synchroniser cannot miss a source
    always @(posedge mclk) begin
        if (fire) begin
            src_lines <= fire_mask;
            hold_r    <= 2'h3;
        end else if (hold_r != 2'h0) begin
            hold_r <= hold_r - 2'h1;
            if (hold_r == 2'h1)
                src_lines <= 8'h00;
        end
    end
    // free-running oscillator, four system cycles per period
    always @(posedge mclk) begin
        div_r           <= div_r + 2'h1;
        osc_period_tick <= div_r[1];
    end
endmodule

// File: bench/rcc_top_tb.sv
// self-checking bench for the reset cause controller
// assumes rcc_top, the source model and the checker are compiled before it
`timescale 1ns/100ps
`include "rcc_map.vh"
module rcc_top_tb;
    reg         mclk = 1'b0;
    reg         rst_n = 1'b0;
    reg         watchdog_config_fuse = 1'b0;
    reg         fire = 1'b0;
    reg  [7:0]  fire_mask = 8'h00;
    reg  [3:0]  reg_addr = 4'h0;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    wire [7:0]  src_lines;
    wire        osc_period_tick;
    wire [15:0] reg_rdata;
    wire        master_system_reset;
    wire        watchdog_enable;
    wire [2:0]  reset_clock_sel;
    wire        osc_clock_release;
    integer     bad_count = 0;
    integer     num_checks = 0;
    integer     i;
    integer     n;
    reg  [15:0] rd;
    reg  [39:0] r;
    always #5 mclk = ~mclk;
    rcc_src_model src_u (.mclk(mclk), .fire(fire), .fire_mask(fire_mask),
        .src_lines(src_lines), .osc_period_tick(osc_period_tick));
    rcc_top dut_u (.mclk(mclk), .rst_n(rst_n), .brown_out_reset(src_lines[7]),
        .external_pin_reset(src_lines[0]), .reset_instruction(src_lines[1]),
        .watchdog_timeout(src_lines[2]), .trap_conflict(src_lines[3]),
        .illegal_opcode(src_lines[4]), .power_save_sleep(src_lines[5]),
        .power_save_idle(src_lines[6]), .watchdog_config_fuse(watchdog_config_fuse),
        .clock_switch_fuse(1'b0), .osc_config_fuse(3'h5), .osc_current_sel(3'h0),
        .crystal_source(1'b1), .osc_period_tick(osc_period_tick), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .master_system_reset(master_system_reset), .watchdog_enable(watchdog_enable),
        .reset_clock_sel(reset_clock_sel), .osc_clock_release(osc_clock_release));
    // ==========================================
    // tasks
    task finish_test;
        begin
            $display("checks %0d mismatches %0d", num_checks, bad_count);
            if (bad_count == 0 && num_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                bad_count = bad_count + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    // optional write, then a read of the same place on the next cycle
    task access(input [3:0] a, input [15:0] d, input w, output [15:0] q);
        begin
            reg_addr  <= a;
            reg_wdata <= d;
            if (w) begin
                reg_wr <= 1'b1;
                @(posedge mclk);
                reg_wr <= 1'b0;
            end
            reg_rd <= 1'b1;
            @(posedge mclk);
            reg_rd <= 1'b0;
            #1 q = reg_rdata;
            @(posedge mclk);
        end
    endtask
    task wait_msr(input lvl, input integer lim, output integer cnt);
        begin
            cnt = 0;
            while (master_system_reset !== lvl) begin
                if (cnt >= lim) begin
                    bad_count = bad_count + 1;
                    $display("BAD t=%0t got=%h exp=%h", $time, master_system_reset, lvl);
                    finish_test;
                end
                @(posedge mclk);
                #1 cnt = cnt + 1;
            end
        end
    endtask
    task por;
        begin
            rst_n <= 1'b0;
            repeat (4) @(posedge mclk);
            rst_n <= 1'b1;
            wait_msr(1'b0, 6000, n);
            chk(n >= 4900, 1'b1);
            access(`RCC_CAUSE_ADDR, 16'h0000, 1'b0, rd);
            chk(rd, `RCC_CAUSE_POR_VAL);
        end
    endtask
    // rows: source mask, value preset by software, cause expected afterwards
    reg  [39:0] rows [0:8];
    initial begin
        rows[0] = {8'h01, 16'h0100, 16'h0180};
        rows[1] = {8'h02, 16'h0000, 16'h0040};
        rows[2] = {8'h04, 16'h0000, 16'h0010};
        rows[3] = {8'h08, 16'h0000, 16'h8000};
        rows[4] = {8'h10, 16'h0000, 16'h4000};
        rows[5] = {8'h20, 16'h0010, 16'h0008};
        rows[6] = {8'h40, 16'h0000, 16'h0004};
        rows[7] = {8'h09, 16'h0000, 16'h8080};
        rows[8] = {8'h80, 16'hc0dc, 16'h0082};
    end
    // ==========================================
    // main sequence
    initial begin
        por;
        chk(watchdog_enable, 1'b0);
        chk(osc_clock_release, 1'b1);
        chk(reset_clock_sel, 3'h5);
        for (i = 0; i < 9; i = i + 1) begin
            r = rows[i];
            access(`RCC_CAUSE_ADDR, r[31:16], 1'b1, rd);
            chk(rd, r[31:16]);
            fire_mask <= r[39:32];
            fire      <= 1'b1;
            @(posedge mclk);
            fire <= 1'b0;
            if (|(r[39:32] & 8'h9f)) begin
                wait_msr(1'b1, 20, n);
                wait_msr(1'b0, 6000, n);
                chk(n >= 1990, 1'b1);
            end else
                repeat (20) @(posedge mclk);
            access(`RCC_CAUSE_ADDR, 16'h0000, 1'b0, rd);
            chk(rd, r[15:0]);
        end
        access(`RCC_CAUSE_ADDR, 16'hffff, 1'b1, rd);
        chk(rd, `RCC_CAUSE_MASK);
        repeat (10) @(posedge mclk);
        chk(master_system_reset, 1'b0);
        chk(watchdog_enable, 1'b1);
        access(4'hf, 16'h1234, 1'b1, rd);
        chk(rd, 16'h0000);
        access(`RCC_CAUSE_ADDR, 16'h0000, 1'b0, rd);
        chk(rd, `RCC_CAUSE_MASK);
        por;
        watchdog_config_fuse <= 1'b1;
        repeat (8) @(posedge mclk);
        chk(watchdog_enable, 1'b1);
        watchdog_config_fuse <= 1'b0;
        repeat (8) @(posedge mclk);
        chk(watchdog_enable, 1'b0);
        finish_test;
    end
endmodule
bind rcc_top rcc_properties chk_u (.mclk, .rst_n, .brown_out_reset, .external_pin_reset,
    .reset_instruction, .watchdog_timeout, .trap_conflict, .illegal_opcode,
    .watchdog_config_fuse, .clock_switch_fuse, .osc_config_fuse, .crystal_source,
    .osc_period_tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .master_system_reset, .watchdog_enable, .reset_clock_sel, .osc_clock_release);
